/* verilog/odac_params.svh */
// Purpose: constants of the octal converter serial command decoder
// Assumes: included by the design file by bare name
// Notes:   timing counts are in clk_sys cycles
`ifndef ODAC_PARAMS_SVH
`define ODAC_PARAMS_SVH

`define ODAC_FRAME_BITS      24
`define ODAC_CMD_MSB         23
`define ODAC_CMD_LSB         20
`define ODAC_ADDR_MSB        19
`define ODAC_ADDR_LSB        16
`define ODAC_DATA_MSB        15
`define ODAC_DATA_LSB        0
`define ODAC_CHAIN_BIT       0
`define ODAC_GAIN_BIT        2
`define ODAC_CHAIN_RST       16'h0000
`define ODAC_MASK_RST        8'h00
`define ODAC_CODE_RST        16'h0000
`define ODAC_PWR_RST         16'h0000
`define ODAC_GAIN_RST        1'b0
`define ODAC_RDBK_RST        4'h0

`endif

/* verilog/odac_pkg.sv */
// Purpose: types of the octal converter serial command decoder
// Assumes: nothing
// Notes:   command codes follow the 4-bit field at the top of each frame
package odac_pkg;

  typedef enum logic [3:0] {
    CMD_NOP        = 4'b0000,
    CMD_WR_IN      = 4'b0001,
    CMD_UPD_SEL    = 4'b0010,
    CMD_WR_UPD     = 4'b0011,
    CMD_POWER      = 4'b0100,
    CMD_MASK       = 4'b0101,
    CMD_SOFT_RST   = 4'b0110,
    CMD_GAIN       = 4'b0111,
    CMD_CHAIN      = 4'b1000,
    CMD_READBACK   = 4'b1001,
    CMD_WR_ALL_IN  = 4'b1010,
    CMD_WR_ALL_UPD = 4'b1011,
    CMD_RSV_C      = 4'b1100,
    CMD_RSV_D      = 4'b1101,
    CMD_RSV_E      = 4'b1110,
    CMD_NOP_CHAIN  = 4'b1111
  } odac_cmd_t;

  typedef struct packed {
    odac_cmd_t   cmd;
    logic [3:0]  addr;
    logic [15:0] data;
  } odac_frame_t;

endpackage : odac_pkg

/* verilog/odac_serial_decoder.sv */
// Purpose: serial command front end of an eight-channel converter
// Assumes: frame select, serial clock, data and load pin are asynchronous pins
// Notes:   pins are sampled by clk_sys; serial clock edges are found by edge detection
`timescale 1ns/1ns
`include "odac_params.svh"

module odac_serial_decoder #(
  parameter int CHANNELS = 8,
  parameter int CODE_W   = 16
) (
  // system
  input  wire logic                       clk_sys,
  input  wire logic                       rst_b,
  // serial link pins
  input  wire logic                       frameSel_n,
  input  wire logic                       serClk,
  input  wire logic                       serDataIn,
  output logic                            serDataOut,
  output logic                            serDataOutEn,
  // hardware load pin
  input  wire logic                       load_pin_n,
  // converter state
  output logic [CHANNELS-1:0][CODE_W-1:0] convCode,
  output logic [CHANNELS*2-1:0]           powerMode,
  output logic                            gainDouble,
  output logic                            chain_enable,
  output logic [CHANNELS-1:0]             loadMask,
  output logic                            frameDone
);

  // pin synchronisers
  logic [1:0] fsSync_q;
  logic [1:0] scSync_q;
  logic [1:0] sdSync_q;
  logic [1:0] ldSync_q;
  logic       fsPrev_q;
  logic       scPrev_q;
  logic       ldPrev_q;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fsSync_q <= 2'h3;
      // serial clock idles high; a low reset value would fake a rising edge
      scSync_q <= 2'h3;
      sdSync_q <= 2'h0;
      ldSync_q <= 2'h3;
      fsPrev_q <= 1'b1;
      scPrev_q <= 1'b1;
      ldPrev_q <= 1'b1;
    end
    else
    begin
      fsSync_q <= {fsSync_q[0], frameSel_n};
      scSync_q <= {scSync_q[0], serClk};
      sdSync_q <= {sdSync_q[0], serDataIn};
      ldSync_q <= {ldSync_q[0], load_pin_n};
      fsPrev_q <= fsSync_q[1];
      scPrev_q <= scSync_q[1];
      ldPrev_q <= ldSync_q[1];
    end
  end

  logic fs;
  logic scFall;
  logic scRise;
  logic fsRise;
  logic ldLow;
  logic ldFall;

  assign fs     = fsSync_q[1];
  assign scFall = scPrev_q & ~scSync_q[1];
  assign scRise = ~scPrev_q & scSync_q[1];
  assign fsRise = ~fsPrev_q & fs;
  assign ldLow  = ~ldSync_q[1];
  assign ldFall = ldPrev_q & ~ldSync_q[1];

  // shift register and bit count
  logic [`ODAC_FRAME_BITS-1:0] shift_q;
  logic [5:0]                  bitCnt_q;
  logic                        softRst;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_q  <= '0;
      bitCnt_q <= 6'h00;
    end
    else if (fs)
      bitCnt_q <= 6'h00;
    else if (scFall)
    begin
      shift_q <= {shift_q[`ODAC_FRAME_BITS-2:0], sdSync_q[1]};
      if (bitCnt_q != 6'h3f)
        bitCnt_q <= bitCnt_q + 6'h01;
    end
  end

  // frame as decoded at frame select rise; partial frames act on what is there
  odac_pkg::odac_frame_t frame;
  assign frame = odac_pkg::odac_frame_t'(shift_q);

  logic                  exec;
  logic [CHANNELS-1:0]   addrHit;
  logic                  addrValid;
  assign exec      = fsRise;
  assign addrValid = (frame.addr < 4'(CHANNELS));

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_addr
      assign addrHit[g] = addrValid && (frame.addr == 4'(g));
    end
  endgenerate

  // control registers
  logic [15:0] chainReg_q;
  logic [7:0]  mask_q;
  logic [15:0] pwr_q;
  logic        gain_q;
  logic [3:0]  rdbkAddr_q;
  logic        rdbkArm_q;

  assign softRst = exec && (frame.cmd == odac_pkg::CMD_SOFT_RST);

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      chainReg_q <= `ODAC_CHAIN_RST;
      mask_q     <= `ODAC_MASK_RST;
      pwr_q      <= `ODAC_PWR_RST;
      gain_q     <= `ODAC_GAIN_RST;
      rdbkAddr_q <= `ODAC_RDBK_RST;
      rdbkArm_q  <= 1'b0;
    end
    else if (softRst)
    begin
      chainReg_q <= `ODAC_CHAIN_RST;
      mask_q     <= `ODAC_MASK_RST;
      pwr_q      <= `ODAC_PWR_RST;
      gain_q     <= `ODAC_GAIN_RST;
      rdbkAddr_q <= `ODAC_RDBK_RST;
      rdbkArm_q  <= 1'b0;
    end
    else if (exec)
    begin
      rdbkArm_q <= 1'b0;
      case (frame.cmd)
        odac_pkg::CMD_POWER:    pwr_q      <= frame.data;
        odac_pkg::CMD_MASK:     mask_q     <= frame.data[7:0];
        odac_pkg::CMD_GAIN:     gain_q     <= frame.data[`ODAC_GAIN_BIT];
        odac_pkg::CMD_CHAIN:    chainReg_q <= frame.data;
        odac_pkg::CMD_READBACK:
        begin
          rdbkAddr_q <= frame.addr;
          rdbkArm_q  <= 1'b1;
        end
        default:                rdbkArm_q  <= 1'b0;
      endcase
    end
  end

  // channel registers
  logic [CHANNELS-1:0][CODE_W-1:0] inReg_q;
  logic [CHANNELS-1:0][CODE_W-1:0] dacReg_q;

  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_chan
      logic wrIn;
      logic wrDac;
      logic pinLoad;
      logic xferSel;
      assign wrIn    = exec && ((frame.cmd == odac_pkg::CMD_WR_IN && addrHit[g])
                              || frame.cmd == odac_pkg::CMD_WR_ALL_IN
                              || frame.cmd == odac_pkg::CMD_WR_ALL_UPD);
      assign wrDac   = exec && ((frame.cmd == odac_pkg::CMD_WR_UPD && addrHit[g])
                              || frame.cmd == odac_pkg::CMD_WR_ALL_UPD);
      assign xferSel = exec && frame.cmd == odac_pkg::CMD_UPD_SEL && frame.data[g];
      // transparent while pin low, or on pin fall between frames, unless masked
      assign pinLoad = !mask_q[g] && ((ldLow && wrIn) || (ldFall && fs));

      always_ff @(posedge clk_sys or negedge rst_b)
      begin
        if (!rst_b)
        begin
          inReg_q[g]  <= `ODAC_CODE_RST;
          dacReg_q[g] <= `ODAC_CODE_RST;
        end
        else if (softRst)
        begin
          inReg_q[g]  <= `ODAC_CODE_RST;
          dacReg_q[g] <= `ODAC_CODE_RST;
        end
        else
        begin
          if (wrIn)
            inReg_q[g] <= frame.data[CODE_W-1:0];
          if (wrDac || (pinLoad && wrIn))
            dacReg_q[g] <= frame.data[CODE_W-1:0];
          else if (xferSel || pinLoad)
            dacReg_q[g] <= inReg_q[g];
        end
      end
    end
  endgenerate

  // serial output: chain ripple or readback stream
  logic [`ODAC_FRAME_BITS-1:0] rdShift_q;
  logic                        rdActive_q;
  logic                        sdo_q;
  logic                        sdoEn_q;
  logic                        chainOn;
  assign chainOn = chainReg_q[`ODAC_CHAIN_BIT];

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdShift_q  <= '0;
      rdActive_q <= 1'b0;
      sdo_q      <= 1'b0;
      sdoEn_q    <= 1'b0;
    end
    else
    begin
      if (exec)
      begin
        rdActive_q <= rdbkArm_q;
        rdShift_q  <= {4'h0, dacReg_q[rdbkAddr_q[2:0]], 4'h0};
      end
      else if (fsRise)
        rdActive_q <= 1'b0;
      sdoEn_q <= chainOn || rdActive_q;
      if (!fs && scRise)
      begin
        if (rdActive_q && bitCnt_q < 6'(`ODAC_FRAME_BITS))
          sdo_q <= rdShift_q[`ODAC_FRAME_BITS-1-bitCnt_q[4:0]];
        else if (chainOn)
          sdo_q <= shift_q[`ODAC_FRAME_BITS-1];
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      convCode     <= '0;
      powerMode    <= '0;
      gainDouble   <= 1'b0;
      chain_enable <= 1'b0;
      loadMask     <= '0;
      frameDone    <= 1'b0;
      serDataOut   <= 1'b0;
      serDataOutEn <= 1'b0;
    end
    else
    begin
      convCode     <= dacReg_q;
      powerMode    <= pwr_q[CHANNELS*2-1:0];
      gainDouble   <= gain_q;
      chain_enable <= chainOn;
      loadMask     <= mask_q[CHANNELS-1:0];
      frameDone    <= exec;
      serDataOut   <= sdo_q;
      serDataOutEn <= sdoEn_q;
    end
  end

endmodule : odac_serial_decoder

/* test/odac_serial_decoder_properties.sv */
// Purpose: port assertions for the serial command decoder
// Assumes: bound to every decoder instance
// Notes:   setting registers may only move with a frame
`timescale 1ns/1ns
module odac_serial_decoder_properties #(
  parameter int CHANNELS = 8,
  parameter int CODE_W   = 16
) (
  // system
  input wire logic                             clk_sys,
  input wire logic                             rst_b,
  // pins
  input wire logic                             frameSel_n,
  input wire logic                             serClk,
  input wire logic                             serDataIn,
  input wire logic                             serDataOut,
  input wire logic                             serDataOutEn,
  input wire logic                             load_pin_n,
  // state
  input wire logic [CHANNELS-1:0][CODE_W-1:0]  convCode,
  input wire logic [CHANNELS*2-1:0]            powerMode,
  input wire logic                             gainDouble,
  input wire logic                             chain_enable,
  input wire logic [CHANNELS-1:0]              loadMask,
  input wire logic                             frameDone
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  property p_pulse; frameDone |=> !frameDone; endproperty
  a_pulse: assert property (p_pulse) else $error("done pulse too long");
  property p_idle; frameDone |-> frameSel_n && $past(frameSel_n); endproperty
  a_idle: assert property (p_idle) else $error("done inside frame");
  property p_chain; $changed(chain_enable) |-> $past(frameDone); endproperty
  a_chain: assert property (p_chain) else $error("chain moved alone");
  property p_mask; $changed(loadMask) |-> $past(frameDone); endproperty
  a_mask: assert property (p_mask) else $error("mask moved alone");
  property p_gain; $changed(gainDouble) |-> $past(frameDone); endproperty
  a_gain: assert property (p_gain) else $error("gain moved alone");
  property p_power; $changed(powerMode) |-> $past(frameDone); endproperty
  a_power: assert property (p_power) else $error("power moved alone");
  property p_masked; $changed(convCode) && &loadMask |-> $past(frameDone); endproperty
  a_masked: assert property (p_masked) else $error("masked code moved");
  property p_sdo; chain_enable && $past(chain_enable) |-> serDataOutEn; endproperty
  a_sdo: assert property (p_sdo) else $error("output off in chain");

  c_done: cover property (frameDone);
  c_chain: cover property ($rose(chain_enable));
  c_gain: cover property ($rose(gainDouble));
endmodule : odac_serial_decoder_properties

bind odac_serial_decoder odac_serial_decoder_properties #(.CHANNELS(CHANNELS), .CODE_W(CODE_W)) u_props (.*);

/* test/odac_host_model.sv */
// Purpose: host serial master driving frames and the load pin
// Assumes: serial clock half period is 4 bench clocks
// Notes:   data line shows the inverse of its last bit between frames
`timescale 1ns/1ns
module odac_host_model (
  // clock
  input  wire logic clk,
  // pins
  output logic      frameSel_n,
  output logic      serClk,
  output logic      serDataIn,
  output logic      load_pin_n
);
  initial
  begin
    frameSel_n = 1'b1;
    serClk     = 1'b1;
    serDataIn  = 1'b0;
    load_pin_n = 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : cyc

  task automatic send(input logic [23:0] w);
    cyc(1);
    frameSel_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      serDataIn = w[i];
      cyc(4);
      serClk = 1'b0;
      cyc(4);
      serClk = 1'b1;
    end
    cyc(6);
    frameSel_n = 1'b1;
    serDataIn  = ~serDataIn;
  endtask : send

  task automatic pulse_load();
    cyc(1);
    load_pin_n = 1'b0;
    cyc(4);
    load_pin_n = 1'b1;
  endtask : pulse_load
endmodule : odac_host_model

/* test/odac_serial_decoder_tb.sv */
// Purpose: self-checking bench of the serial command decoder
// Assumes: host model drives every pin
// Notes:   expected codes kept in expCode
`timescale 1ns/1ns
module odac_serial_decoder_tb;
  logic              clk_sys;
  logic              rst_b;
  logic              frameSel_n;
  logic              serClk;
  logic              serDataIn;
  logic              load_pin_n;
  logic              serDataOut;
  logic              serDataOutEn;
  logic [7:0][15:0]  convCode;
  logic [7:0][15:0]  expCode;
  logic [15:0]       powerMode;
  logic              gainDouble;
  logic              chain_enable;
  logic [7:0]        loadMask;
  logic              frameDone;
  int                miscompares = 0;
  int                checked = 0;

  initial clk_sys = 1'b0;
  always #10 clk_sys = ~clk_sys;

  odac_host_model u_odac_host_model (.clk(clk_sys), .frameSel_n(frameSel_n), .serClk(serClk),
    .serDataIn(serDataIn), .load_pin_n(load_pin_n));
  odac_serial_decoder u_odac_serial_decoder (.clk_sys(clk_sys), .rst_b(rst_b), .frameSel_n(frameSel_n),
    .serClk(serClk), .serDataIn(serDataIn), .serDataOut(serDataOut), .serDataOutEn(serDataOutEn),
    .load_pin_n(load_pin_n), .convCode(convCode), .powerMode(powerMode), .gainDouble(gainDouble),
    .chain_enable(chain_enable), .loadMask(loadMask), .frameDone(frameDone));

  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic frame(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
    int n;
    u_odac_host_model.send({c, a, d});
    n = 0;
    while (frameDone !== 1'b1 && n < 30)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (frameDone !== 1'b1)
    begin
      miscompares++;
      stop_test();
    end
    @(negedge clk_sys);
  endtask : frame

  task automatic t_all();
    frame(odac_pkg::CMD_WR_ALL_IN, 4'h0, 16'h2222);
    chk(convCode, '0);
    frame(odac_pkg::CMD_WR_ALL_UPD, 4'h0, 16'h3333);
    expCode = {8{16'h3333}};
    chk(convCode, expCode);
    $display("test all done");
  endtask : t_all

  task automatic t_load();
    frame(odac_pkg::CMD_WR_IN, 4'h5, 16'habcd);
    chk(convCode, expCode);
    u_odac_host_model.pulse_load();
    repeat (8) @(negedge clk_sys);
    expCode[5] = 16'habcd;
    chk(convCode, expCode);
    frame(odac_pkg::CMD_WR_IN, 4'h2, 16'h5555);
    frame(odac_pkg::CMD_UPD_SEL, 4'h0, 16'h0004);
    expCode[2] = 16'h5555;
    chk(convCode, expCode);
    frame(odac_pkg::CMD_MASK, 4'h0, 16'h00ff);
    chk(loadMask, 8'hff);
    frame(odac_pkg::CMD_WR_IN, 4'h1, 16'h7777);
    u_odac_host_model.pulse_load();
    repeat (8) @(negedge clk_sys);
    chk(convCode, expCode);
    frame(odac_pkg::CMD_MASK, 4'h0, 16'h0000);
    $display("test load done");
  endtask : t_load

  task automatic t_address();
    for (int i = 0; i < 8; i++)
    begin
      expCode[i] = 16'h1000 + 16'(i);
      frame(odac_pkg::CMD_WR_UPD, 4'(i), expCode[i]);
    end
    frame(odac_pkg::CMD_WR_UPD, 4'h9, 16'hdead);
    chk(convCode, expCode);
    $display("test address done");
  endtask : t_address

  task automatic t_modes();
    logic [3:0] idle [5] = '{4'h0, 4'hc, 4'hd, 4'he, 4'hf};
    frame(odac_pkg::CMD_POWER, 4'h0, 16'hc1a5);
    frame(odac_pkg::CMD_GAIN, 4'h0, 16'h0004);
    frame(odac_pkg::CMD_CHAIN, 4'h0, 16'h0001);
    chk({powerMode, gainDouble, chain_enable}, {16'hc1a5, 2'b11});
    @(negedge clk_sys);
    chk(serDataOutEn, 1'b1);
    frame(odac_pkg::CMD_READBACK, 4'h5, 16'h0000);
    foreach (idle[i])
      frame(idle[i], 4'h1, 16'hffff);
    chk(serDataOut, 1'b1);
    chk(convCode, expCode);
    chk({powerMode, gainDouble, chain_enable, loadMask}, {16'hc1a5, 2'b11, 8'h00});
    frame(odac_pkg::CMD_SOFT_RST, 4'h0, 16'h0000);
    chk(convCode, '0);
    chk({powerMode, gainDouble, chain_enable, loadMask}, '0);
    $display("test modes done");
  endtask : t_modes

  initial
  begin
    rst_b = 1'b0;
    repeat (3) @(posedge clk_sys);
    #2;
    rst_b = 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({powerMode, gainDouble, chain_enable, loadMask}, '0);
    t_all();
    t_load();
    t_address();
    t_modes();
    stop_test();
  end
endmodule : odac_serial_decoder_tb
